// ### hw/ufc_params.svh
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH
`define UFC_OFS_DATA 3'h0
`define UFC_OFS_IEN 3'h1
`define UFC_OFS_IID 3'h2
`define UFC_OFS_LCR 3'h3
`define UFC_OFS_MCR 3'h4
`define UFC_OFS_LSR 3'h5
`define UFC_OFS_MSR 3'h6
`define UFC_OFS_SCR 3'h7
`define UFC_FC_EN 0
`define UFC_FC_RXCLR 1
`define UFC_FC_TXCLR 2
`define UFC_FC_DMA 3
`define UFC_LC_BANK 7
`define UFC_FIFO_DEPTH 16
`define UFC_IID_RESET 8'h01
`define UFC_LSR_RESET 8'h60
`endif

// ### hw/ufc_pkg.sv
package ufc_pkg;
   typedef logic [7:0] ufc_byte_t;
   typedef logic [4:0] ufc_cnt_t;
endpackage : ufc_pkg

// ### hw/ufc_fifo.sv
module ufc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk_i, // Clock
   input wire logic rst_n_i, // Sync reset
   input wire logic flush_i, // Empty the buffer
   input wire logic in_valid_i, // Write valid
   output logic in_ready_o, // Not full
   input wire logic [WIDTH-1:0] in_data_i, // Write data
   output logic out_valid_o, // Not empty
   input wire logic out_ready_i, // Read accept
   output logic [WIDTH-1:0] out_data_o, // Head word
   output logic [$clog2(DEPTH):0] count_o // Fill level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready_o = cnt_q != DEPTH[AW:0];
   assign out_valid_o = cnt_q != '0;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem_q[rd_q];
   assign count_o = cnt_q;

   always_ff @(posedge ref_clk_i)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i || flush_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= rd_q + 1'b1;
         end
         cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule : ufc_fifo

// ### hw/ufc_regs.sv
`include "ufc_params.svh"
module ufc_regs
   import ufc_pkg::*;
(
   input wire logic ref_clk_i, // 25 MHz clock
   input wire logic rst_n_i, // Master reset, active low
   input wire logic [2:0] addr_i, // Register address
   input wire logic cs_i, // Chip select
   input wire logic wr_i, // Write strobe, one cycle
   input wire logic rd_i, // Read strobe, one cycle
   input wire logic [7:0] wdata_i, // Write data
   output logic [7:0] rdata_o, // Read data, registered
   input wire logic rx_valid_i, // Received byte from shifter
   input wire logic [7:0] rx_data_i, // Received byte, bit 0 first on line
   output logic rx_ready_o, // Receive path can take a byte
   output logic tx_valid_o, // Byte ready for the shifter
   output logic [7:0] tx_data_o, // Byte to send, bit 0 first
   input wire logic tx_ready_i, // Shifter takes the byte
   input wire logic timeout_i, // Character time-out seen
   input wire logic rx_error_i, // Error held in receive data
   output logic rx_irq_o, // Received data available
   output logic receive_dma_request_o, // Receive DMA request
   output logic transmit_dma_request_o, // Transmit DMA request
   output logic [15:0] divisor_o, // Baud divisor
   output logic [7:0] line_control_o, // Line control
   output logic [7:0] modem_control_o // Modem control
);
   ufc_byte_t fc_q;
   ufc_byte_t ien_q;
   ufc_byte_t lc_q;
   ufc_byte_t mc_q;
   ufc_byte_t scr_q;
   ufc_byte_t dll_q;
   ufc_byte_t dlm_q;
   logic wr_fc;
   logic en_new;
   logic flush_rx;
   logic flush_tx;
   logic bank;
   logic fifo_on;
   ufc_cnt_t rx_cnt;
   ufc_cnt_t tx_cnt;
   ufc_cnt_t trig;
   ufc_byte_t rx_head;
   logic rx_nonempty;
   logic tx_full;
   logic rx_pop;
   logic tx_push;
   ufc_byte_t iid;
   ufc_byte_t line_status;
   ufc_byte_t rd_d;

   function automatic ufc_cnt_t trig_level(input logic [1:0] sel);
      unique case (sel)
         2'b00: trig_level = 5'd1;
         2'b01: trig_level = 5'd4;
         2'b10: trig_level = 5'd8;
         2'b11: trig_level = 5'd14;
      endcase
   endfunction : trig_level

   assign bank = lc_q[`UFC_LC_BANK];
   assign wr_fc = cs_i && wr_i && addr_i == `UFC_OFS_IID;
   assign en_new = wdata_i[`UFC_FC_EN];
   assign fifo_on = fc_q[`UFC_FC_EN];
   assign flush_rx = wr_fc && ((en_new != fifo_on) || (en_new && wdata_i[`UFC_FC_RXCLR]));
   assign flush_tx = wr_fc && ((en_new != fifo_on) || (en_new && wdata_i[`UFC_FC_TXCLR]));
   assign trig = fifo_on ? trig_level(fc_q[7:6]) : 5'd1;
   assign rx_pop = cs_i && rd_i && addr_i == `UFC_OFS_DATA && !bank;
   assign tx_push = cs_i && wr_i && addr_i == `UFC_OFS_DATA && !bank;

   assign rx_ready_o = fifo_on ? (rx_cnt != 5'd16) : (rx_cnt == 5'd0);
   assign tx_full = fifo_on ? (tx_cnt == 5'd16) : (tx_cnt != 5'd0);

   ufc_fifo #(.WIDTH(8), .DEPTH(`UFC_FIFO_DEPTH)) u_rx (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .flush_i(flush_rx),
      .in_valid_i(rx_valid_i && rx_ready_o),
      .in_ready_o(),
      .in_data_i(rx_data_i),
      .out_valid_o(rx_nonempty),
      .out_ready_i(rx_pop),
      .out_data_o(rx_head),
      .count_o(rx_cnt)
   );

   ufc_fifo #(.WIDTH(8), .DEPTH(`UFC_FIFO_DEPTH)) u_tx (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .flush_i(flush_tx),
      .in_valid_i(tx_push && !tx_full),
      .in_ready_o(),
      .in_data_i(wdata_i),
      .out_valid_o(tx_valid_o),
      .out_ready_i(tx_ready_i),
      .out_data_o(tx_data_o),
      .count_o(tx_cnt)
   );

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         fc_q <= 8'h00;
      end
      else if (wr_fc)
      begin
         if (en_new)
         begin
            fc_q <= {wdata_i[7:6], 2'b00, wdata_i[3], 3'b001};
         end
         else
         begin
            fc_q[`UFC_FC_EN] <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         ien_q <= 8'h00;
         lc_q <= 8'h00;
         mc_q <= 8'h00;
      end
      else if (cs_i && wr_i)
      begin
         if (addr_i == `UFC_OFS_IEN && !bank)
         begin
            ien_q <= {4'h0, wdata_i[3:0]};
         end
         if (addr_i == `UFC_OFS_LCR)
         begin
            lc_q <= wdata_i;
         end
         if (addr_i == `UFC_OFS_MCR)
         begin
            mc_q <= {2'b00, wdata_i[5:0]};
         end
      end
   end

   // Divisor and scratch are untouched by master reset
   always_ff @(posedge ref_clk_i)
   begin
      if (cs_i && wr_i)
      begin
         if (addr_i == `UFC_OFS_DATA && bank)
         begin
            dll_q <= wdata_i;
         end
         if (addr_i == `UFC_OFS_IEN && bank)
         begin
            dlm_q <= wdata_i;
         end
         if (addr_i == `UFC_OFS_SCR)
         begin
            scr_q <= wdata_i;
         end
      end
   end

   assign rx_irq_o = fifo_on ? (ien_q[0] && rx_cnt >= trig) : (ien_q[0] && rx_nonempty);

   // Only receive-data and time-out ids; other sources live elsewhere
   always_comb
   begin
      iid = `UFC_IID_RESET;
      // time-out id only in FIFO mode
      if (fifo_on && ien_q[0] && timeout_i && rx_nonempty)
      begin
         iid[3:0] = 4'hc;
      end
      else if (rx_irq_o)
      begin
         iid[3:0] = 4'h4;
      end
      iid[7:6] = {2{fifo_on}};
   end

   always_comb
   begin
      line_status = `UFC_LSR_RESET;
      line_status[0] = rx_nonempty;
      line_status[5] = !tx_valid_o;
      line_status[6] = !tx_valid_o && tx_ready_i;
      // error flag masked in character mode
      line_status[7] = fifo_on && rx_error_i;
   end

   always_comb
   begin
      rd_d = 8'h00;
      unique case (addr_i)
         `UFC_OFS_DATA: rd_d = bank ? dll_q : rx_head;
         `UFC_OFS_IEN: rd_d = bank ? dlm_q : ien_q;
         `UFC_OFS_IID: rd_d = iid;
         `UFC_OFS_LCR: rd_d = lc_q;
         `UFC_OFS_MCR: rd_d = mc_q;
         `UFC_OFS_LSR: rd_d = line_status;
         `UFC_OFS_MSR: rd_d = 8'h00;
         `UFC_OFS_SCR: rd_d = scr_q;
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         rdata_o <= 8'h00;
      end
      else if (cs_i && rd_i)
      begin
         rdata_o <= rd_d;
      end
   end

   // DMA mode 0 single byte, mode 1 by trigger and full
   assign receive_dma_request_o = (fifo_on && fc_q[`UFC_FC_DMA]) ? (rx_cnt >= trig)
                                                                  : rx_nonempty;
   assign transmit_dma_request_o = (fifo_on && fc_q[`UFC_FC_DMA]) ? !tx_full : !tx_valid_o;
   assign divisor_o = {dlm_q, dll_q};
   assign line_control_o = lc_q;
   assign modem_control_o = mc_q;

   property p_flush_on_change;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (wr_fc && en_new != fifo_on) |=> (rx_cnt == 5'd0 && tx_cnt == 5'd0);
   endproperty
   a_flush_on_change: assert property (p_flush_on_change) else $error("enable change kept data");

   property p_rx_clear;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (wr_fc && en_new && wdata_i[1]) |=> rx_cnt == 5'd0;
   endproperty
   a_rx_clear: assert property (p_rx_clear) else $error("rx flush failed");

   property p_tx_clear;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (wr_fc && en_new && wdata_i[2]) |=> tx_cnt == 5'd0;
   endproperty
   a_tx_clear: assert property (p_tx_clear) else $error("tx flush failed");

   property p_ignore_off;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (wr_fc && !en_new) |=> fc_q[3] == $past(fc_q[3]) && fc_q[7:6] == $past(fc_q[7:6]);
   endproperty
   a_ignore_off: assert property (p_ignore_off) else $error("bits programmed with enable clear");

   property p_selfclear;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_fc |=> fc_q[2:1] == 2'b00 && fc_q[5:4] == 2'b00;
   endproperty
   a_selfclear: assert property (p_selfclear) else $error("clear bits stuck");

   property p_trig;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (fifo_on && ien_q[0]) |-> rx_irq_o == (rx_cnt >= trig_level(fc_q[7:6]));
   endproperty
   a_trig: assert property (p_trig) else $error("rx irq not at trigger");

   property p_iid_mode;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (cs_i && rd_i && addr_i == `UFC_OFS_IID) |=> rdata_o[7:6] == {2{$past(fifo_on)}};
   endproperty
   a_iid_mode: assert property (p_iid_mode) else $error("fifo mode bits wrong");

   property p_char_mode;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !fifo_on |-> !iid[3] && !line_status[7] && rx_cnt <= 5'd1 && tx_cnt <= 5'd1;
   endproperty
   a_char_mode: assert property (p_char_mode) else $error("char mode broken");

   // Mode 1 paces the host by fill level, not by single bytes
   property p_tx_dma_mode1;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (fifo_on && fc_q[`UFC_FC_DMA]) |-> transmit_dma_request_o == (tx_cnt != 5'd16);
   endproperty
   a_tx_dma_mode1: assert property (p_tx_dma_mode1) else $error("tx dma mode 1 wrong");

   property p_rx_dma_mode0;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !(fifo_on && fc_q[`UFC_FC_DMA]) |-> receive_dma_request_o == (rx_cnt != 5'd0);
   endproperty
   a_rx_dma_mode0: assert property (p_rx_dma_mode0) else $error("rx dma mode 0 wrong");

   // Divisor reads must not pop the receive buffer
   property p_bank_read;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (cs_i && rd_i && addr_i == `UFC_OFS_DATA && bank && !rx_valid_i)
      |=> rx_cnt == $past(rx_cnt);
   endproperty
   a_bank_read: assert property (p_bank_read) else $error("divisor read popped data");

   property p_iid_char;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (cs_i && rd_i && addr_i == `UFC_OFS_IID && !fifo_on) |=> rdata_o[3] == 1'b0;
   endproperty
   a_iid_char: assert property (p_iid_char) else $error("time-out id in char mode");

   c_dma1: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      fc_q[`UFC_FC_DMA] && fifo_on && !transmit_dma_request_o);
   c_timeout: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) iid[3:0] == 4'hc);
   c_flush: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) flush_rx && rx_cnt > 5'd2);
   c_trig14: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      rx_irq_o && fc_q[7:6] == 2'b11);
   c_full: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) tx_full && fifo_on);
endmodule : ufc_regs

// ### dv/ufc_shifter_model.sv
module ufc_shifter_model (
   input wire logic ref_clk_i, // Clock
   input wire logic tx_valid_i, // Byte offered
   input wire logic [7:0] tx_data_i, // Offered byte
   output logic tx_ready_o, // Shifter free
   output logic rx_valid_o, // Received byte valid
   output logic [7:0] rx_data_o, // Received byte
   input wire logic rx_ready_i // Push accepted
);
   timeunit 1ns;
   timeprecision 1ns;
   logic stall = 1'b0;
   logic take = 1'b0;
   logic [7:0] held = 8'h00;
   logic [7:0] got[$];
   initial
   begin
      tx_ready_o = 1'b1;
      rx_valid_o = 1'b0;
      rx_data_o = 8'h00;
   end
   // Decided early so the pop edge sees settled data
   always @(negedge ref_clk_i)
   begin
      tx_ready_o = !stall;
      take = tx_valid_i && tx_ready_o;
      held = tx_data_i;
   end
   always @(posedge ref_clk_i)
   begin
      if (take)
      begin
         got.push_back(held);
      end
   end
   task automatic push(input logic [7:0] b);
      @(negedge ref_clk_i);
      rx_valid_o = 1'b1;
      rx_data_o = b;
      for (int k = 0; k < 50 && !rx_ready_i; k++)
         @(negedge ref_clk_i);
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      rx_valid_o = 1'b0;
      // Released bus must not keep the old byte
      rx_data_o = ~b;
   endtask : push
endmodule : ufc_shifter_model

// ### dv/testbench.sv
module testbench
   import ufc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {ufc_byte_t fc; int lvl;} ufc_row_t;
   ufc_row_t rows[4] = '{'{8'h07, 1}, '{8'h47, 4}, '{8'h87, 8}, '{8'hc7, 14}};
   logic clk, rst_n, cs, wr, rd, rx_valid, rx_ready, tx_valid, tx_ready;
   logic timeout, rx_error, rx_irq, rdreq, tdreq;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, rx_data, tx_data, lc, mc, v;
   logic [15:0] divisor;
   int fails = 0;
   int n_checks = 0;
   int cycles = 0;
   ufc_regs ufc_regs_inst (.ref_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .cs_i(cs),
      .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata), .rx_valid_i(rx_valid),
      .rx_data_i(rx_data), .rx_ready_o(rx_ready), .tx_valid_o(tx_valid),
      .tx_data_o(tx_data), .tx_ready_i(tx_ready), .timeout_i(timeout),
      .rx_error_i(rx_error), .rx_irq_o(rx_irq), .receive_dma_request_o(rdreq),
      .transmit_dma_request_o(tdreq), .divisor_o(divisor), .line_control_o(lc),
      .modem_control_o(mc));
   ufc_shifter_model ufc_shifter_model_inst (.ref_clk_i(clk), .tx_valid_i(tx_valid),
      .tx_data_i(tx_data), .tx_ready_o(tx_ready), .rx_valid_o(rx_valid),
      .rx_data_o(rx_data), .rx_ready_i(rx_ready));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic conclude();
      if (fails == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         fails++;
         conclude();
      end
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e)
      begin
         fails++;
         $display("Error at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic chk1(input logic g, input logic e);
      chk({7'h00, g}, {7'h00, e});
   endtask : chk1
   task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk);
      {cs, wr, addr, wdata} = {2'b11, a, d};
      @(negedge clk);
      {cs, wr} = 2'b00;
   endtask : bus_wr
   task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
      @(negedge clk);
      {cs, rd, addr} = {2'b11, a};
      @(negedge clk);
      {cs, rd} = 2'b00;
      d = rdata;
   endtask : bus_rd
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
      bus_rd(a, v);
      chk(v, e);
   endtask : rd_chk
   task automatic push(input logic [7:0] b);
      ufc_shifter_model_inst.push(b);
   endtask : push
   task automatic rst_chk();
      rd_chk(3'h2, 8'h01);
      rd_chk(3'h5, 8'h60);
      chk1(tdreq, 1'b1);
      chk1(rdreq, 1'b0);
      chk1(rx_irq, 1'b0);
      chk1(tx_valid, 1'b0);
      chk(lc, 8'h00);
   endtask : rst_chk
   initial
   begin
      {rst_n, cs, wr, rd, addr, wdata, timeout, rx_error} = '0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      rst_chk();
      bus_wr(3'h1, 8'h01);
      foreach (rows[r])
      begin
         bus_wr(3'h2, rows[r].fc);
         for (int i = 0; i < 16; i++)
         begin
            chk1(rx_irq, i >= rows[r].lvl);
            push(8'(i) ^ 8'ha5);
         end
         chk1(rx_ready, 1'b0);
         rd_chk(3'h2, 8'hc4);
         for (int i = 0; i < 16; i++)
            rd_chk(3'h0, 8'(i) ^ 8'ha5);
         chk1(rx_irq, 1'b0);
      end
      bus_wr(3'h2, 8'h49);
      push(8'h11);
      chk1(rdreq, 1'b0);
      chk1(tdreq, 1'b1);
      bus_wr(3'h2, 8'h71);
      chk1(rdreq, 1'b1);
      rd_chk(3'h2, 8'hc1);
      timeout = 1'b1;
      rd_chk(3'h2, 8'hcc);
      bus_wr(3'h2, 8'h00);
      chk1(rdreq, 1'b0);
      rd_chk(3'h2, 8'h01);
      rx_error = 1'b1;
      push(8'h22);
      chk1(rx_ready, 1'b0);
      rd_chk(3'h2, 8'h04);
      bus_rd(3'h5, v);
      chk1(v[7], 1'b0);
      // Bit 0 clear: other bits must be ignored
      bus_wr(3'h2, 8'hc6);
      rd_chk(3'h2, 8'h04);
      rd_chk(3'h0, 8'h22);
      {timeout, rx_error} = 2'b00;
      ufc_shifter_model_inst.stall = 1'b1;
      bus_wr(3'h2, 8'h01);
      push(8'h33);
      bus_wr(3'h0, 8'h5a);
      bus_wr(3'h0, 8'h3c);
      chk1(tx_valid, 1'b1);
      chk(tx_data, 8'h5a);
      chk1(tdreq, 1'b0);
      bus_wr(3'h2, 8'h05);
      chk1(tx_valid, 1'b0);
      chk1(rdreq, 1'b1);
      ufc_shifter_model_inst.got.delete();
      // One write past full must be dropped
      for (int i = 0; i < 17; i++)
         bus_wr(3'h0, 8'(i) + 8'h40);
      bus_wr(3'h2, 8'h09);
      chk1(tdreq, 1'b0);
      chk1(rdreq, 1'b1);
      ufc_shifter_model_inst.stall = 1'b0;
      for (int k = 0; k < 100 && ufc_shifter_model_inst.got.size() < 16; k++)
         @(negedge clk);
      repeat (4) @(negedge clk);
      chk(8'(ufc_shifter_model_inst.got.size()), 8'h10);
      for (int i = 0; i < 16; i++)
         chk(ufc_shifter_model_inst.got[i], 8'(i) + 8'h40);
      bus_wr(3'h3, 8'h80);
      bus_wr(3'h0, 8'h34);
      bus_wr(3'h1, 8'h12);
      chk(divisor[7:0], 8'h34);
      chk(divisor[15:8], 8'h12);
      rd_chk(3'h0, 8'h34);
      bus_wr(3'h3, 8'h03);
      chk(lc, 8'h03);
      rd_chk(3'h0, 8'h33);
      rd_chk(3'h1, 8'h01);
      bus_wr(3'h7, 8'h5a);
      rd_chk(3'h7, 8'h5a);
      bus_wr(3'h4, 8'h0b);
      chk(mc, 8'h0b);
      bus_wr(3'h2, 8'h01);
      push(8'h44);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      rst_chk();
      conclude();
   end
endmodule : testbench
